//--- core/dgp_consts.vh
/*
  dgp_consts.vh: register offsets, field positions and reset values of the
  dual gpio port block.
  assumes: included by bare name from the core design files.
*/
`ifndef DGP_CONSTS_VH
`define DGP_CONSTS_VH

// printed offsets 0 and 1 are not word multiples: they are indices
`define DGP_IDX_PORT_A_DATA 4'h0
`define DGP_IDX_PORT_B_DATA 4'h1
`define DGP_IDX_PORT_A_DIRECTION 4'h4
`define DGP_IDX_PORT_B_DIRECTION 4'h5
`define DGP_IDX_PORT_A_PULLUP_ENABLE 4'h6
`define DGP_IDX_CONFIG 4'h7

`define DGP_PA_WIDTH 6
`define DGP_PB_WIDTH 8
`define DGP_INPUT_ONLY_BIT 2
`define DGP_CLOCK_OUT_BIT 4
`define DGP_WAKEUP_BIT 6
`define DGP_CLOCK_OUT_EN_BIT 7

// config fields: bit 0 irq pin enable, bits 2:1 oscillator option
`define DGP_CFG_IRQ_EN_BIT 0
`define DGP_CFG_OSC_LSB 1
`define DGP_CFG_OSC_MSB 2
`define DGP_OSC_INTERNAL 2'h0
`define DGP_OSC_EXTERNAL 2'h1
`define DGP_OSC_RC 2'h2
`define DGP_OSC_CRYSTAL 2'h3

`define DGP_RST_DIRECTION_A 6'h00
`define DGP_RST_DIRECTION_B 8'h00
`define DGP_RST_PULLUP 8'h00
`define DGP_RST_CONFIG 3'h0

`endif

//--- core/dgp_pin_sync.v
/*
  dgp_pin_sync.v: two-flop synchroniser for a group of pin levels.
  assumes: pins asynchronous to mclk; no reset needed on the data path.
*/
`timescale 1ns/1ps
`default_nettype none

module dgp_pin_sync #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge mclk) begin
    meta <= async_in;
    sync_out <= meta;
  end

endmodule // dgp_pin_sync

`default_nettype wire

//--- core/dgp_ports.v
/*
  dgp_ports.v: six-pin port a and eight-pin port b with data and direction
  registers, plus a port a pullup register, behind an apb slave.
  assumes: pins arrive asynchronously and are synchronised here; pads do
  the tristate resolution from the _oe outputs; the wakeup latch and the
  oscillator clock come from elsewhere in the chip.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dgp_consts.vh"

// Operation
// - six-pin port a with per-pin latches
// - irq enabled: bit 2 reads zero
// - irq disabled: branch sees one, pin read
// - port a latches untouched by reset
// - bit 6 mirrors wakeup latch, read-only
// - port a direction one enables driver, except on input-only pin 2
// - reset clears port a direction
// - port a read: latch if output else pin, except pin 2 (pin or zero, set by irq enable)
// - data writes always update latches
// - input-pin writes touch only latch
// - pullup only when enabled and input
// - clock out on pin 4 if enabled and oscillator option internal or rc
// - eight-pin port b with latches
// - port b direction one enables driver
// - reset clears port b direction only
// - port b read: latch if output else pin
// - clock out is undivided oscillator clock
module dgp_ports #(
  parameter HAS_PORT_B = 1
) (
  input wire mclk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [5:0] port_a_pin_in,
  output reg [5:0] port_a_pin_out,
  output reg [5:0] port_a_pin_oe,
  output reg [5:0] port_a_pullup_on,
  input wire [7:0] port_b_pin_in,
  output reg [7:0] port_b_pin_out,
  output reg [7:0] port_b_pin_oe,
  input wire wakeup_latch,
  input wire raw_oscillator_clock,
  output reg branch_if_int_pin_high
);

  reg [5:0] port_a_data;
  reg [5:0] port_a_direction;
  reg [7:0] port_a_pullup_enable;
  reg [7:0] port_b_data;
  reg [7:0] port_b_direction;
  reg [2:0] config_reg;
  reg wakeup_latch_mirror;
  reg [1:0] access_state;
  reg [31:0] next_prdata;
  reg next_err;
  reg [7:0] rd_byte;
  reg [5:0] a_rd;
  wire [5:0] port_a_sync;
  wire [7:0] port_b_sync;
  wire wake_sync;
  wire osc_sync;
  reg [7:0] a_mix;
  reg [5:0] next_a_out;
  reg [5:0] next_a_oe;
  reg [5:0] next_a_pullup;
  reg [7:0] next_b_out;
  reg [7:0] next_b_oe;
  wire wr_ok;
  wire wr_a_data;
  wire wr_b_data;
  wire wr_a_dir;
  wire wr_b_dir;
  wire wr_pullup;
  wire wr_cfg;
  wire irq_enabled;
  wire [1:0] osc_option;
  wire clock_out_active;
  wire [3:0] reg_index;
  wire index_aligned;
  wire wr_take;

  // one-hot access states
  localparam ST_IDLE = 2'b01;
  localparam ST_DONE = 2'b10;

  // mixes latch and pin per bit, shared by both port reads
  function [7:0] port_read;
    input [7:0] latch;
    input [7:0] pins;
    input [7:0] dir;
    begin
      port_read = (latch & dir) | (pins & ~dir);
    end
  endfunction

  // write strobe for one register index, shared by every write process
  function wr_sel;
    input take;
    input [3:0] idx;
    input [3:0] want;
    begin
      wr_sel = take && (idx == want);
    end
  endfunction

  dgp_pin_sync #(.WIDTH(6)) u_sync_a (
    .mclk(mclk),
    .async_in(port_a_pin_in),
    .sync_out(port_a_sync)
  );

  dgp_pin_sync #(.WIDTH(8)) u_sync_b (
    .mclk(mclk),
    .async_in(port_b_pin_in),
    .sync_out(port_b_sync)
  );

  // wakeup latch comes from another block and is treated as foreign
  dgp_pin_sync #(.WIDTH(1)) u_sync_wake (
    .mclk(mclk),
    .async_in(wakeup_latch),
    .sync_out(wake_sync)
  );

  // oscillator clock is resampled, so it must stay below mclk / 2
  dgp_pin_sync #(.WIDTH(1)) u_sync_osc (
    .mclk(mclk),
    .async_in(raw_oscillator_clock),
    .sync_out(osc_sync)
  );

  assign irq_enabled = config_reg[`DGP_CFG_IRQ_EN_BIT];
  assign osc_option = config_reg[`DGP_CFG_OSC_MSB:`DGP_CFG_OSC_LSB];
  assign clock_out_active =
    port_a_pullup_enable[`DGP_CLOCK_OUT_EN_BIT] &&
    ((osc_option == `DGP_OSC_INTERNAL) ||
     (osc_option == `DGP_OSC_RC));

  // printed offsets are word indices: byte address is four times index
  assign reg_index = paddr[5:2];
  assign index_aligned = (paddr[1:0] == 2'b00) && (paddr[11:6] == 6'h00);
  assign wr_take = psel && penable && pready && pwrite;
  // a refused write must not land: pslverr stands beside pready
  assign wr_ok = wr_take && index_aligned && !pslverr;
  assign wr_a_data = wr_sel(wr_ok, reg_index, `DGP_IDX_PORT_A_DATA);
  assign wr_b_data = wr_sel(wr_ok, reg_index, `DGP_IDX_PORT_B_DATA);
  assign wr_a_dir = wr_sel(wr_ok, reg_index, `DGP_IDX_PORT_A_DIRECTION);
  assign wr_b_dir = wr_sel(wr_ok, reg_index, `DGP_IDX_PORT_B_DIRECTION);
  assign wr_pullup = wr_sel(wr_ok, reg_index, `DGP_IDX_PORT_A_PULLUP_ENABLE);
  assign wr_cfg = wr_sel(wr_ok, reg_index, `DGP_IDX_CONFIG);

  // port a read byte: pin 2 doubles as the interrupt pin
  always @* begin
    a_mix = port_read({2'b00, port_a_data}, {2'b00, port_a_sync},
      {2'b00, port_a_direction});
    a_rd = a_mix[5:0];
    if (irq_enabled) begin
      a_rd[`DGP_INPUT_ONLY_BIT] = 1'b0;
    end else begin
      a_rd[`DGP_INPUT_ONLY_BIT] =
        port_a_sync[`DGP_INPUT_ONLY_BIT];
    end
  end

  // read mux, also flags unmapped offsets
  always @* begin
    rd_byte = 8'h00;
    next_err = 1'b0;
    if (!index_aligned) begin
      next_err = 1'b1;
    end else begin
      case (reg_index)
        `DGP_IDX_PORT_A_DATA: begin
          rd_byte = {1'b0, wakeup_latch_mirror, a_rd};
        end
        `DGP_IDX_PORT_B_DATA: begin
          if (HAS_PORT_B != 0) begin
            rd_byte = port_read(port_b_data, port_b_sync,
              port_b_direction);
          end else begin
            next_err = 1'b1;
          end
        end
        `DGP_IDX_PORT_A_DIRECTION: begin
          rd_byte = {2'b00, port_a_direction};
        end
        `DGP_IDX_PORT_B_DIRECTION: begin
          if (HAS_PORT_B != 0) begin
            rd_byte = port_b_direction;
          end else begin
            next_err = 1'b1;
          end
        end
        `DGP_IDX_PORT_A_PULLUP_ENABLE: begin
          rd_byte = port_a_pullup_enable & 8'hbf;
        end
        `DGP_IDX_CONFIG: begin
          rd_byte = {5'h00, config_reg};
        end
        default: begin
          next_err = 1'b1;
        end
      endcase
    end
    next_prdata = {24'h000000, rd_byte};
  end

  // one wait state: pready rises in the second access cycle
  always @(posedge mclk) begin
    if (!resetn) begin
      access_state <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      case (access_state)
        ST_IDLE: begin
          pready <= 1'b0;
          pslverr <= 1'b0;
          if (psel && penable) begin
            access_state <= ST_DONE;
            pready <= 1'b1;
            pslverr <= next_err;
            prdata <= pwrite ? 32'h00000000 : next_prdata;
          end
        end
        ST_DONE: begin
          // pready stood for one edge; the master releases now
          access_state <= ST_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
        default: begin
          access_state <= ST_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  // data latches keep their value through reset
  always @(posedge mclk) begin
    if (wr_a_data) begin
      port_a_data <= pwdata[5:0];
    end
    if (wr_b_data) begin
      port_b_data <= pwdata[7:0];
    end
  end

  // control registers; bit 6 of the pullup word has no pin behind it
  always @(posedge mclk) begin
    if (!resetn) begin
      port_a_direction <= `DGP_RST_DIRECTION_A;
      port_b_direction <= `DGP_RST_DIRECTION_B;
      port_a_pullup_enable <= `DGP_RST_PULLUP;
      config_reg <= `DGP_RST_CONFIG;
    end else begin
      if (wr_a_dir) begin
        port_a_direction <= pwdata[5:0];
      end
      if (wr_b_dir && (HAS_PORT_B != 0)) begin
        port_b_direction <= pwdata[7:0];
      end
      if (wr_pullup) begin
        port_a_pullup_enable <= pwdata[7:0] & 8'hbf;
      end
      if (wr_cfg) begin
        config_reg <= pwdata[2:0];
      end
    end
  end

  // port a pad controls ahead of their output register
  always @* begin
    next_a_out = port_a_data;
    next_a_oe = port_a_direction;
    next_a_oe[`DGP_INPUT_ONLY_BIT] = 1'b0;
    next_a_pullup = port_a_pullup_enable[5:0] &
      ~port_a_direction;
    if (clock_out_active) begin
      // resampled clock: edges jitter by one mclk period
      next_a_out[`DGP_CLOCK_OUT_BIT] = osc_sync;
      next_a_oe[`DGP_CLOCK_OUT_BIT] = 1'b1;
      next_a_pullup[`DGP_CLOCK_OUT_BIT] = 1'b0;
    end
  end

  // port b pads stay released when the port is built out
  always @* begin
    if (HAS_PORT_B != 0) begin
      next_b_out = port_b_data;
      next_b_oe = port_b_direction;
    end else begin
      next_b_out = 8'h00;
      next_b_oe = 8'h00;
    end
  end

  // pad registers: outputs leave the block straight from flops
  always @(posedge mclk) begin
    if (!resetn) begin
      port_a_pin_out <= 6'h00;
      port_a_pin_oe <= 6'h00;
      port_a_pullup_on <= 6'h00;
      port_b_pin_out <= 8'h00;
      port_b_pin_oe <= 8'h00;
    end else begin
      port_a_pin_out <= next_a_out;
      port_a_pin_oe <= next_a_oe;
      port_a_pullup_on <= next_a_pullup;
      port_b_pin_out <= next_b_out;
      port_b_pin_oe <= next_b_oe;
    end
  end

  // wakeup mirror and the level the branch test sees
  always @(posedge mclk) begin
    if (!resetn) begin
      wakeup_latch_mirror <= 1'b0;
      branch_if_int_pin_high <= 1'b1;
    end else begin
      wakeup_latch_mirror <= wake_sync;
      branch_if_int_pin_high <= irq_enabled ?
        port_a_sync[`DGP_INPUT_ONLY_BIT] : 1'b1;
    end
  end

endmodule // dgp_ports

`default_nettype wire

//--- tb/dgp_chk.sv
/* dgp_chk.sv: assertions on the port block's bus and pin outputs.
   assumes: bound to dgp_ports; one clock, sync active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module dgp_chk #(
  parameter HAS_PORT_B = 1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] port_a_pin_in,
  input wire logic [5:0] port_a_pin_out,
  input wire logic [5:0] port_a_pin_oe,
  input wire logic [5:0] port_a_pullup_on,
  input wire logic [7:0] port_b_pin_in,
  input wire logic [7:0] port_b_pin_out,
  input wire logic [7:0] port_b_pin_oe,
  input wire logic wakeup_latch,
  input wire logic raw_oscillator_clock,
  input wire logic branch_if_int_pin_high
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire done = psel && penable && pready && pwrite && !pslverr;
  wire wr_a = done && paddr == 12'h000;
  wire wr_b = done && paddr == 12'h004;
  property p_in_only;
    !port_a_pin_oe[2];
  endproperty
  a_in_only: assert property (p_in_only)
    else $error("pin 2 driven");
  property p_a_rst;
    $rose(resetn) |-> port_a_pin_oe == 6'h00;
  endproperty
  a_a_rst: assert property (p_a_rst)
    else $error("port a drives after reset");
  property p_b_rst;
    $rose(resetn) |-> port_b_pin_oe == 8'h00;
  endproperty
  a_b_rst: assert property (p_b_rst)
    else $error("port b drives after reset");
  property p_pullup;
    (port_a_pullup_on & port_a_pin_oe) == 6'h00;
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pullup on a driven pin");
  // pin 4 excluded: it may carry the clock instead of the latch
  property p_a_follow;
    wr_a |-> ##2 ((port_a_pin_out ^ $past(pwdata[5:0], 2))
      & port_a_pin_oe & 6'h2f) == 6'h00;
  endproperty
  a_a_follow: assert property (p_a_follow)
    else $error("port a output misses write");
  property p_b_follow;
    wr_b |-> ##2 ((port_b_pin_out ^ $past(pwdata[7:0], 2))
      & port_b_pin_oe) == 8'h00;
  endproperty
  a_b_follow: assert property (p_b_follow)
    else $error("port b output misses write");
  property p_rdy_next;
    psel && penable && !pready |=> pready;
  endproperty
  a_rdy_next: assert property (p_rdy_next)
    else $error("no answer");
  property p_rdy_once;
    pready |=> !pready;
  endproperty
  a_rdy_once: assert property (p_rdy_once)
    else $error("ready held");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy)
    else $error("error without ready");
  property p_no_b;
    (HAS_PORT_B == 0) && pready && (paddr == 12'h004 || paddr == 12'h014)
      |-> pslverr && port_b_pin_oe == 8'h00;
  endproperty
  a_no_b: assert property (p_no_b)
    else $error("absent port b answered");
endmodule // dgp_chk
bind dgp_ports dgp_chk #(.HAS_PORT_B(HAS_PORT_B)) u_chk (
  .mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .port_a_pin_in, .port_a_pin_out, .port_a_pin_oe,
  .port_a_pullup_on, .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe,
  .wakeup_latch, .raw_oscillator_clock, .branch_if_int_pin_high
);
`default_nettype wire

//--- tb/dgp_pins_model.sv
/* dgp_pins_model.sv: board side of both ports.
   assumes: bench sets the board level of every undriven line. */
`timescale 1ns/1ps
`default_nettype none
module dgp_pins_model (
  input wire logic [5:0] a_out,
  input wire logic [5:0] a_oe,
  input wire logic [5:0] a_pu,
  input wire logic [5:0] a_ext,
  output logic [5:0] a_lvl,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic [7:0] b_ext,
  output logic [7:0] b_lvl
);
  assign a_lvl = (a_oe & a_out) | (~a_oe & (a_pu | a_ext));
  assign b_lvl = (b_oe & b_out) | (~b_oe & b_ext);
endmodule // dgp_pins_model
`default_nettype wire

//--- tb/tb.sv
/* tb.sv: self-checking bench for the dual port block over apb.
   assumes: design, pin model and checker compiled before. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, r = 32'h6f9a;
  logic wakeup_latch = 0, raw_oscillator_clock = 0, p4;
  logic [5:0] ext_a = 0, ma, xa;
  logic [7:0] ext_b = 0, mb, da, db, pu;
  logic [11:0] bad [4] = '{12'h008, 12'h002, 12'h040, 12'h03c};
  wire [31:0] prdata;
  wire pready, pslverr, branch_if_int_pin_high;
  wire [5:0] port_a_pin_in, port_a_pin_out, port_a_pin_oe;
  wire [5:0] port_a_pullup_on;
  wire [7:0] port_b_pin_in, port_b_pin_out, port_b_pin_oe;
  logic [32:0] exq [$];
  int num_errors = 0, n_tests = 0, rises;
  dgp_ports #(.HAS_PORT_B(1)) DUT (.mclk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .port_a_pin_in, .port_a_pin_out, .port_a_pin_oe, .port_a_pullup_on,
    .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe, .wakeup_latch,
    .raw_oscillator_clock, .branch_if_int_pin_high);
  dgp_pins_model pins (.a_out(port_a_pin_out), .a_oe(port_a_pin_oe),
    .a_pu(port_a_pullup_on), .a_ext(ext_a), .a_lvl(port_a_pin_in),
    .b_out(port_b_pin_out), .b_oe(port_b_pin_oe), .b_ext(ext_b),
    .b_lvl(port_b_pin_in));
  // variant without port b on the same bus; watched by its checker
  dgp_ports #(.HAS_PORT_B(0)) dut_nob (.mclk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(),
    .port_a_pin_in, .port_a_pin_out(), .port_a_pin_oe(),
    .port_a_pullup_on(), .port_b_pin_in, .port_b_pin_out(),
    .port_b_pin_oe(), .wakeup_latch, .raw_oscillator_clock,
    .branch_if_int_pin_high());
  initial forever #20 mclk = ~mclk;
  // slow raw clock so the resampled copy keeps every edge
  initial begin
    #7;
    forever #200 raw_oscillator_clock = ~raw_oscillator_clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task roll;
    repeat (32) r = lfsr(r);
  endtask
  task automatic cmp(input logic [32:0] g, input logic [32:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp({25'h0, g}, {25'h0, e});
  endtask
  task wrap_up;
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    exq.push_back(e);
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00, {25'h0, e});
  endtask
  task rst;
    resetn <= 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
  endtask
  always @(posedge mclk)
    if (psel && penable && pready === 1'b1) begin : mon
      logic [32:0] e;
      e = exq.pop_front();
      cmp({pslverr, e[32] ? 32'h0 : prdata}, e);
    end
  initial begin
    rst;
    for (int i = 0; i < 16; i++) begin
      roll;
      ma = r[5:0];
      mb = r[15:8];
      da = r[23:16];
      db = r[31:24];
      roll;
      xa = r[5:0];
      ext_a <= r[5:0];
      ext_b <= r[15:8];
      pu = {2'b00, r[21:16]};
      wakeup_latch <= r[24];
      wr(12'h000, da);
      wr(12'h004, db);
      wr(12'h010, {2'b00, ma});
      wr(12'h014, mb);
      wr(12'h018, pu);
      repeat (4) @(posedge mclk);
      chk({2'b00, port_a_pin_oe}, {2'b00, ma & 6'h3b});
      chk({2'b00, port_a_pullup_on}, pu & {2'b00, ~ma});
      chk(port_b_pin_oe, mb);
      rd(12'h000, {1'b0, wakeup_latch, (da[5:0] & ma & 6'h3b) |
        (~(ma & 6'h3b) & ((pu[5:0] & ~ma) | xa))});
      rd(12'h004, (db & mb) | (~mb & ext_b));
    end
    rst;
    rd(12'h010, 8'h00);
    rd(12'h014, 8'h00);
    wr(12'h010, 8'h3f);
    wr(12'h014, 8'hff);
    rd(12'h000, {1'b0, wakeup_latch, da[5:3], xa[2], da[1:0]});
    rd(12'h004, db);
    wr(12'h004, 8'h96);
    rd(12'h004, 8'h96);
    for (int k = 0; k < 4; k++)
      xfer(k[0], bad[k], 8'hff, {1'b1, 32'h0});
    wr(12'h010, 8'h00);
    wr(12'h018, 8'h00);
    wr(12'h01c, 8'h01);
    for (int v = 0; v < 2; v++) begin
      ext_a <= {3'b000, v[0], 2'b00};
      repeat (4) @(posedge mclk);
      chk({7'h0, branch_if_int_pin_high}, {7'h0, v[0]});
      rd(12'h000, {1'b0, wakeup_latch, 6'h00});
    end
    wr(12'h01c, 8'h00);
    repeat (4) @(posedge mclk);
    chk({7'h0, branch_if_int_pin_high}, 8'h01);
    rd(12'h000, {1'b0, wakeup_latch, 6'h04});
    wr(12'h018, 8'h80);
    for (int o = 0; o < 4; o++) begin
      wr(12'h01c, {5'h00, o[1:0], 1'b0});
      repeat (4) @(posedge mclk);
      rises = 0;
      p4 = port_a_pin_out[4];
      repeat (100) begin
        @(posedge mclk);
        if (port_a_pin_out[4] && !p4) rises++;
        p4 = port_a_pin_out[4];
      end
      chk({7'h0, port_a_pin_oe[4]}, {7'h0, !o[0]});
      chk(rises[7:0], o[0] ? 8'h00 : 8'h0a);
    end
    wrap_up;
  end
  initial begin
    #400000;
    num_errors++;
    wrap_up;
  end
endmodule // tb
`default_nettype wire
